// ### hw/fwsr_bus_cycle.sv
`timescale 1ns/1ps
module fwsr_bus_cycle
    import fwsr_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           reset,
    input  wire logic           req_valid,
    input  wire fwsr_cycle_type req,
    input  wire logic [15:0]    dq_in,
    output logic                done,
    output logic [15:0]         rd_data,
    output fwsr_pins_type       pins
);

    // ==========================================================
    // state
    typedef struct packed {
        fwsr_eng_type  st;
        logic [7:0]    cnt;
        logic          wr;
        logic [15:0]   rd_data;
        logic          done;
        logic [15:0]   s1;
        logic [15:0]   s2;
        logic [15:0]   s3;
        fwsr_pins_type pins;
    } fwsr_eng_state_type;

    localparam fwsr_eng_state_type ENG_RESET = '{st: E_IDLE, cnt: 8'h00, wr: 1'b0, rd_data: 16'h0000,
                                                 done: 1'b0, s1: 16'h0000, s2: 16'h0000, s3: 16'h0000,
                                                 pins: PINS_RESET};

    fwsr_eng_state_type q;
    fwsr_eng_state_type next_q;

    // ==========================================================
    // one bus cycle
    always_comb begin
        next_q      = q;
        next_q.done = 1'b0;
        next_q.s1   = dq_in;
        next_q.s2   = q.s1;
        next_q.s3   = q.s2;
        unique case (q.st)
            E_IDLE: begin
                if (req_valid) begin
                    next_q.st          = E_SETUP;
                    next_q.wr          = req.wr;
                    next_q.pins.addr   = req.addr;
                    next_q.pins.dq_out = req.data;
                    next_q.pins.dq_oe  = req.wr;
                    next_q.pins.ce_n   = 1'b0;
                end
            end
            E_SETUP: begin
                // chip select already low: the write strobe falls later and latches the address
                next_q.st = E_LOW;
                if (q.wr) begin
                    next_q.pins.we_n = 1'b0;
                    next_q.cnt       = WE_LOW_CYC;
                end else begin
                    next_q.pins.oe_n = 1'b0;
                    next_q.cnt       = READ_WAIT_CYC;
                end
            end
            E_LOW: begin
                if (q.cnt != 8'h00) begin
                    next_q.cnt = q.cnt - 8'h01;
                end else if (q.wr) begin
                    // data stays driven past the strobes' rising edge
                    next_q.pins.we_n = 1'b1;
                    next_q.pins.ce_n = 1'b1;
                    next_q.st        = E_HIGH;
                    next_q.cnt       = WE_HIGH_CYC;
                end else if (q.s2 == q.s3) begin
                    next_q.rd_data   = q.s3;
                    next_q.pins.oe_n = 1'b1;
                    next_q.pins.ce_n = 1'b1;
                    next_q.st        = E_HIGH;
                    next_q.cnt       = WE_HIGH_CYC;
                end
            end
            E_HIGH: begin
                next_q.pins.dq_oe = 1'b0;
                if (q.cnt != 8'h00) begin
                    next_q.cnt = q.cnt - 8'h01;
                end else begin
                    next_q.st   = E_IDLE;
                    next_q.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= ENG_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign done    = q.done;
    assign rd_data = q.rd_data;
    assign pins    = q.pins;

endmodule : fwsr_bus_cycle

// ### hw/fwsr_host.sv
`timescale 1ns/1ps
module fwsr_host
    import fwsr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] flash_dq_in,
    input  wire logic        ready_busy_n,
    output fwsr_pins_type    flash_pins
);

    // ==========================================================
    // state
    typedef struct packed {
        fwsr_main_type  st;
        fwsr_op_type    op;
        logic [18:0]    addr;
        logic [15:0]    wdata;
        logic [15:0]    rdata;
        logic [2:0]     idx;
        logic           pend;
        logic           first;
        logic           tog_prev;
        logic           fail_seen;
        logic           done;
        logic           fail;
        logic           refused;
        logic           bypass;
        logic           req_valid;
        fwsr_cycle_type req;
        logic           rb1;
        logic           rb2;
        logic           rb3;
        logic           rb_ready;
        logic [31:0]    prdata;
    } fwsr_state_type;

    localparam fwsr_state_type MAIN_RESET = '{st: M_IDLE, op: OP_READ, addr: 19'h00000, wdata: 16'h0000,
                                              rdata: 16'h0000, idx: 3'h0, pend: 1'b0, first: 1'b0,
                                              tog_prev: 1'b0, fail_seen: 1'b0, done: 1'b0, fail: 1'b0,
                                              refused: 1'b0, bypass: 1'b0, req_valid: 1'b0,
                                              req: CYCLE_RESET, rb1: 1'b1, rb2: 1'b1, rb3: 1'b1,
                                              rb_ready: 1'b1, prdata: 32'h00000000};

    fwsr_state_type q;
    fwsr_state_type next_q;
    logic           bus_done;
    logic [15:0]    bus_rd;

    // ==========================================================
    // command sequences
    function automatic fwsr_cycle_type cyc(input logic wr, input logic [18:0] a, input logic [15:0] d);
        fwsr_cycle_type c;
        c.wr   = wr;
        c.addr = a;
        c.data = d;
        return c;
    endfunction : cyc

    // unlock cycles carry zero upper data and upper address bits
    function automatic fwsr_cycle_type seq_cycle(input fwsr_op_type op, input logic [2:0] i,
                                                 input logic [18:0] a, input logic [15:0] d);
        fwsr_cycle_type c;
        c = cyc(1'b0, a, 16'h0000);
        unique case (op)
            OP_READ:           c = cyc(1'b0, a, 16'h0000);
            OP_RESET:          c = cyc(1'b1, ADDR_ANY, D_RESET);
            OP_SUSPEND:        c = cyc(1'b1, ADDR_ANY, D_SUSPEND);
            OP_RESUME:         c = cyc(1'b1, ADDR_ANY, D_RESUME);
            OP_BYPASS_PROGRAM: c = (i == 3'h0) ? cyc(1'b1, ADDR_ANY, D_PROGRAM) : cyc(1'b1, a, d);
            OP_BYPASS_RESET:   c = (i == 3'h0) ? cyc(1'b1, ADDR_ANY, D_AUTOSEL) : cyc(1'b1, ADDR_ANY, D_BYP_EXIT);
            default: begin
                unique case ((op == OP_SECTOR_ERASE || op == OP_CHIP_ERASE || i < 3'h3) ? i : 3'h7)
                    3'h0, 3'h3: c = cyc(1'b1, UNLOCK_A1, D_UNLOCK1);
                    3'h1, 3'h4: c = cyc(1'b1, UNLOCK_A2, D_UNLOCK2);
                    3'h2: begin
                        unique case (op)
                            OP_PROGRAM:      c = cyc(1'b1, UNLOCK_A1, D_PROGRAM);
                            OP_AUTOSELECT:   c = cyc(1'b1, UNLOCK_A1, D_AUTOSEL);
                            OP_BYPASS_ENTER: c = cyc(1'b1, UNLOCK_A1, D_BYPASS);
                            default:         c = cyc(1'b1, UNLOCK_A1, D_ERASE);
                        endcase
                    end
                    default: begin
                        if (op == OP_PROGRAM && i == 3'h3) begin
                            c = cyc(1'b1, a, d);
                        end else if (op == OP_AUTOSELECT && i == 3'h3) begin
                            // fourth cycle is a read of the code at the given address
                            c = cyc(1'b0, a, 16'h0000);
                        end else if (op == OP_AUTOSELECT) begin
                            // leave identification mode again
                            c = cyc(1'b1, ADDR_ANY, D_RESET);
                        end else if (op == OP_SECTOR_ERASE) begin
                            c = cyc(1'b1, a, D_SECTOR);
                        end else begin
                            c = cyc(1'b1, UNLOCK_A1, D_CHIP);
                        end
                    end
                endcase
            end
        endcase
        return c;
    endfunction : seq_cycle

    function automatic logic [2:0] seq_last(input fwsr_op_type op);
        logic [2:0] n;
        unique case (op)
            OP_PROGRAM:                        n = 3'h3;
            OP_AUTOSELECT:                     n = 3'h4;
            OP_SECTOR_ERASE, OP_CHIP_ERASE:    n = 3'h5;
            OP_BYPASS_ENTER:                   n = 3'h2;
            OP_BYPASS_PROGRAM, OP_BYPASS_RESET: n = 3'h1;
            default:                           n = 3'h0;
        endcase
        return n;
    endfunction : seq_last

    function automatic logic needs_poll(input fwsr_op_type op);
        return op == OP_PROGRAM || op == OP_BYPASS_PROGRAM || op == OP_SECTOR_ERASE || op == OP_CHIP_ERASE;
    endfunction : needs_poll

    function automatic logic mapped(input logic [7:0] a);
        return a == REG_CTRL || a == REG_ADDR || a == REG_WDATA || a == REG_RDATA || a == REG_STATUS;
    endfunction : mapped

    // ==========================================================
    // registers, sequencing and polling
    always_comb begin
        next_q           = q;
        next_q.req_valid = 1'b0;
        next_q.rb1       = ready_busy_n;
        next_q.rb2       = q.rb1;
        next_q.rb3       = q.rb2;
        if (q.rb2 == q.rb3) begin
            // pin level after the last write strobe reflects busy or ready
            next_q.rb_ready = q.rb3;
        end

        // apb read data captured in the setup phase
        if (psel && !penable) begin
            unique case (paddr)
                REG_CTRL:   next_q.prdata = {28'h0000000, q.op};
                REG_ADDR:   next_q.prdata = {13'h0000, q.addr};
                REG_WDATA:  next_q.prdata = {16'h0000, q.wdata};
                REG_RDATA:  next_q.prdata = {16'h0000, q.rdata};
                REG_STATUS: next_q.prdata = {26'h0000000, q.rb_ready, q.bypass, q.refused, q.fail, q.done,
                                             q.st != M_IDLE};
                default:    next_q.prdata = 32'h00000000;
            endcase
        end

        if (psel && penable && pwrite) begin
            unique case (paddr)
                REG_ADDR:   next_q.addr = pwdata[18:0];
                REG_WDATA:  next_q.wdata = pwdata[15:0];
                REG_STATUS: begin
                    if (pwdata[ST_DONE]) next_q.done = 1'b0;
                    if (pwdata[ST_FAIL]) next_q.fail = 1'b0;
                    if (pwdata[ST_REFUSED]) next_q.refused = 1'b0;
                end
                REG_CTRL: begin
                    if (q.st != M_IDLE || pwdata[3:0] >= 4'(OP_COUNT)) begin
                        next_q.refused = 1'b1;
                    end else if (fwsr_op_type'(pwdata[3:0]) == OP_BYPASS_PROGRAM && !q.bypass) begin
                        next_q.refused = 1'b1;
                    end else if (q.bypass && !(fwsr_op_type'(pwdata[3:0]) inside
                                 {OP_BYPASS_PROGRAM, OP_BYPASS_RESET, OP_READ})) begin
                        next_q.refused = 1'b1;
                    end else begin
                        next_q.op        = fwsr_op_type'(pwdata[3:0]);
                        next_q.st        = M_CMD;
                        next_q.idx       = 3'h0;
                        next_q.pend      = 1'b0;
                        next_q.fail_seen = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        unique case (q.st)
            M_IDLE: ;
            M_CMD: begin
                if (!q.pend) begin
                    next_q.req       = seq_cycle(q.op, q.idx, q.addr, q.wdata);
                    next_q.req_valid = 1'b1;
                    next_q.pend      = 1'b1;
                end else if (bus_done) begin
                    next_q.pend = 1'b0;
                    if (!q.req.wr) next_q.rdata = bus_rd;
                    if (q.idx == seq_last(q.op)) begin
                        if (needs_poll(q.op)) begin
                            next_q.st    = M_POLL;
                            next_q.first = 1'b1;
                        end else begin
                            next_q.st   = M_IDLE;
                            next_q.done = 1'b1;
                            if (q.op == OP_BYPASS_ENTER) next_q.bypass = 1'b1;
                            if (q.op == OP_BYPASS_RESET) next_q.bypass = 1'b0;
                        end
                    end else begin
                        next_q.idx = q.idx + 3'h1;
                    end
                end
            end
            M_POLL: begin
                if (!q.pend) begin
                    // status is read at the programmed address or the erased sector
                    next_q.req       = cyc(1'b0, q.addr, 16'h0000);
                    next_q.req_valid = 1'b1;
                    next_q.pend      = 1'b1;
                end else if (bus_done) begin
                    next_q.pend     = 1'b0;
                    next_q.first    = 1'b0;
                    next_q.tog_prev = bus_rd[TOGGLE_POS];
                    if (!q.first && bus_rd[TOGGLE_POS] == q.tog_prev) begin
                        // toggling stopped: fetch the word once more
                        next_q.st = M_FINAL;
                    end else if (!q.first && q.fail_seen) begin
                        next_q.st = M_ABORT;
                    end else begin
                        next_q.fail_seen = q.fail_seen | bus_rd[TIMEOUT_POS];
                    end
                end
            end
            M_FINAL: begin
                if (!q.pend) begin
                    next_q.req       = cyc(1'b0, q.addr, 16'h0000);
                    next_q.req_valid = 1'b1;
                    next_q.pend      = 1'b1;
                end else if (bus_done) begin
                    next_q.pend  = 1'b0;
                    next_q.rdata = bus_rd;
                    next_q.st    = M_IDLE;
                    next_q.done  = 1'b1;
                end
            end
            M_ABORT: begin
                if (!q.pend) begin
                    // timeout flag seen while still toggling: return to array reads
                    next_q.req       = cyc(1'b1, ADDR_ANY, D_RESET);
                    next_q.req_valid = 1'b1;
                    next_q.pend      = 1'b1;
                end else if (bus_done) begin
                    next_q.pend = 1'b0;
                    next_q.st   = M_IDLE;
                    next_q.fail = 1'b1;
                    next_q.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= MAIN_RESET;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // flash bus cycles
    fwsr_bus_cycle u_bus (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .req_valid (q.req_valid),
        .req       (q.req),
        .dq_in     (flash_dq_in),
        .done      (bus_done),
        .rd_data   (bus_rd),
        .pins      (flash_pins)
    );

    assign prdata  = q.prdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

endmodule : fwsr_host

// ### hw/fwsr_pkg.sv
package fwsr_pkg;

    // ==========================================================
    // timing
    localparam int         CLK_MHZ       = 200;
    localparam int         WE_LOW_NS     = 50;
    localparam int         WE_HIGH_NS    = 30;
    localparam int         READ_ACC_NS   = 100;
    localparam int         SYNC_EXTRA    = 2;
    localparam logic [7:0] WE_LOW_CYC    = 8'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WE_HIGH_CYC   = 8'((WE_HIGH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] READ_WAIT_CYC = 8'((READ_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_EXTRA);

    // ==========================================================
    // flash bus values
    localparam int          ADDR_W      = 19;
    localparam int          DATA_W      = 16;
    localparam logic [18:0] UNLOCK_A1   = 19'h00555;
    localparam logic [18:0] UNLOCK_A2   = 19'h002aa;
    localparam logic [18:0] ADDR_ANY    = 19'h00000;
    localparam logic [15:0] D_UNLOCK1   = 16'h00aa;
    localparam logic [15:0] D_UNLOCK2   = 16'h0055;
    localparam logic [15:0] D_PROGRAM   = 16'h00a0;
    localparam logic [15:0] D_ERASE     = 16'h0080;
    localparam logic [15:0] D_CHIP      = 16'h0010;
    localparam logic [15:0] D_SECTOR    = 16'h0030;
    localparam logic [15:0] D_RESET     = 16'h00f0;
    localparam logic [15:0] D_AUTOSEL   = 16'h0090;
    localparam logic [15:0] D_BYPASS    = 16'h0020;
    localparam logic [15:0] D_BYP_EXIT  = 16'h0000;
    localparam logic [15:0] D_SUSPEND   = 16'h00b0;
    localparam logic [15:0] D_RESUME    = 16'h0030;
    localparam int          TOGGLE_POS  = 6;
    localparam int          TIMEOUT_POS = 5;

    // ==========================================================
    // apb register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int         ST_BUSY    = 0;
    localparam int         ST_DONE    = 1;
    localparam int         ST_FAIL    = 2;
    localparam int         ST_REFUSED = 3;
    localparam int         ST_BYPASS  = 4;
    localparam int         ST_READY   = 5;
    localparam int         OP_COUNT   = 11;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_RESET, OP_AUTOSELECT,
        OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_RESET, OP_SUSPEND, OP_RESUME
    } fwsr_op_type;

    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_LOW, E_HIGH} fwsr_eng_type;
    typedef enum logic [2:0] {M_IDLE, M_CMD, M_POLL, M_FINAL, M_ABORT} fwsr_main_type;

    typedef struct packed {
        logic        wr;
        logic [18:0] addr;
        logic [15:0] data;
    } fwsr_cycle_type;

    typedef struct packed {
        logic [18:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
    } fwsr_pins_type;

    localparam fwsr_pins_type PINS_RESET = '{addr: 19'h00000, dq_out: 16'h0000, dq_oe: 1'b0,
                                             ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    localparam fwsr_cycle_type CYCLE_RESET = '{wr: 1'b0, addr: 19'h00000, data: 16'h0000};

endpackage : fwsr_pkg

// ### tb/fwsr_flash_model.sv
`timescale 1ns/1ps
module fwsr_flash_model import fwsr_pkg::*; (
    input wire fwsr_pins_type pins,
    input wire logic          fail_on,
    output logic [15:0]       dq,
    output logic              ready_busy_n
);
    logic [15:0] mem [int] = '{default: 16'hffff};
    logic [15:0] w, held, val;
    logic [18:0] a;
    logic        pd7, tgl, asel, ers, erz;
    int          busy, step;
    wire         stb_n = pins.we_n | pins.ce_n;
    wire         rd_n  = pins.oe_n | pins.ce_n;
    // ========
    // status reads and command writes
    initial {held, pd7, tgl, asel, ers, erz} = '0;
    assign val = busy > 0 ? {8'h00, ~pd7, tgl, fail_on, 2'h0, ers & tgl & (pins.addr[18:12] == a[18:12]), 2'h0}
               : asel ? {15'h0, pins.addr[18]} : mem[pins.addr];
    assign dq = rd_n ? ~held : val;
    assign ready_busy_n = busy > 0 ? 1'b0 : 1'b1;
    always @(negedge stb_n) a = pins.addr;
    always @(posedge rd_n) begin
        held = val;
        if (busy > 0) begin
            tgl = ~tgl;
            busy = fail_on ? busy : busy - 1;
        end
    end
    always @(posedge stb_n) begin
        w = pins.dq_out;
        if (step == 3) begin
            pd7 = w[7];
            ers = 0;
            busy = 3;
            step = 0;
            if (!a[18] && !fail_on) mem[a] = w;
        end else if (w[7:0] == 8'hf0) begin
            busy = 0;
            asel = 0;
            step = 0;
        end else if (w[7:0] == 8'haa) step = 1;
        else if (step == 1 && w[7:0] == 8'h55) step = 2;
        else if ((step == 2 || a == 0) && w[7:0] == 8'ha0) step = 3;
        else if (step == 2 && w[7:0] == 8'h80) begin
            erz = 1;
            step = 0;
        end else if (step == 2 && erz && (w[7:0] == 8'h30 || w[7:0] == 8'h10)) begin
            pd7 = 1;
            busy = 3;
            ers = 1;
            erz = 0;
            step = 0;
            foreach (mem[k])
                if (!k[18] && (!w[5] || k[18:12] == a[18:12])) mem[k] = 16'hffff;
        end else begin
            asel = step == 2 && w[7:0] == 8'h90;
            step = 0;
        end
    end
endmodule : fwsr_flash_model

// ### tb/fwsr_host_assertions.sv
`timescale 1ns/1ps
module fwsr_host_assertions import fwsr_pkg::*; (
    input wire logic          sys_clk,
    input wire logic          reset,
    input wire fwsr_pins_type flash_pins
);
    fwsr_pins_type pin;
    assign pin = flash_pins;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ========
    // flash pin framing
    chk_write_framed:
        assert property (!pin.we_n |-> !pin.ce_n && pin.oe_n && pin.dq_oe) else $error("write not framed");
    chk_read_framed:
        assert property (!pin.oe_n |-> !pin.ce_n && !pin.dq_oe) else $error("read not framed");
    chk_strobe_width:
        assert property ($fell(pin.we_n) |-> !pin.we_n [*8]) else $error("write strobe short");
    chk_write_steady:
        assert property (!pin.we_n && !$past(pin.we_n) |-> $stable(pin.addr) && $stable(pin.dq_out))
        else $error("write bus moved");
    chk_data_hold:
        assert property ($rose(pin.we_n) |-> pin.ce_n && pin.dq_oe) else $error("data not held");
    chk_poll_address:
        assert property (!pin.oe_n && !$past(pin.oe_n) |-> $stable(pin.addr)) else $error("read address moved");
    chk_read_width:
        assert property ($fell(pin.oe_n) |-> !pin.oe_n [*8]) else $error("read strobe short");
endmodule : fwsr_host_assertions
bind fwsr_host fwsr_host_assertions i_fwsr_host_assertions (.sys_clk(sys_clk), .reset(reset),
    .flash_pins(flash_pins));

// ### tb/fwsr_host_test.sv
`timescale 1ns/1ps
module fwsr_host_test import fwsr_pkg::*;;
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, ready_busy_n, fail_on, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] flash_dq_in, dq, d;
    logic [18:0] a;
    fwsr_pins_type flash_pins;
    logic [15:0] exp_mem [int] = '{default: 16'hffff};
    int fail_count, checks_done, seed;
    assign flash_dq_in = flash_pins.dq_oe ? flash_pins.dq_out : dq;
    fwsr_host i_fwsr_host (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n), .flash_pins(flash_pins));
    fwsr_flash_model i_model (.pins(flash_pins), .fail_on(fail_on), .dq(dq), .ready_busy_n(ready_busy_n));
    // ========
    // helpers
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge sys_clk) penable <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
        @(posedge sys_clk);
    endtask : apb
    task automatic op(input logic [3:0] c);
        int n;
        n = 0;
        apb(1, REG_CTRL, {28'h0, c});
        do begin
            apb(0, REG_STATUS, 0);
            n++;
        end while (q[ST_BUSY] !== 1'b0 && n < 500);
        if (n >= 500) begin
            fail_count++;
            final_report();
        end
    endtask : op
    task automatic stat(input logic [31:0] m, input logic [31:0] e);
        apb(0, REG_STATUS, 0);
        check("status", e, q & m);
        apb(1, REG_STATUS, 32'h0e);
    endtask : stat
    // ========
    // main sequence
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        reset = 1;
        {psel, penable, pwrite, paddr, pwdata, fail_on} = '0;
        seed = 41403;
        repeat (6) @(posedge sys_clk);
        reset <= 0;
        @(posedge sys_clk);
        apb(0, 8'h14, 0);
        check("unmapped", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            a = {i == 1, 18'(rnd())};
            d = 16'(rnd());
            fail_on <= i == 3;
            apb(1, REG_ADDR, {13'h0, a});
            apb(1, REG_WDATA, {16'h0, d});
            op(OP_PROGRAM);
            stat(32'h3f, i == 3 ? 32'h26 : 32'h22);
            if (i < 3 && !a[18]) exp_mem[a] = d;
            fail_on <= 0;
            op(OP_READ);
            apb(0, REG_RDATA, 0);
            check("array", {16'h0, exp_mem[a]}, q);
        end
        apb(1, REG_ADDR, 32'h00123);
        exp_mem[19'h00123] = d;
        for (int i = 0; i < 6; i++) begin
            op(4'(24'hb76478 >> (20 - 4 * i)));
            stat(32'h18, {24'h0, 8'(48'h080810181000 >> (40 - 8 * i))});
        end
        op(OP_READ);
        apb(0, REG_RDATA, 0);
        check("bypass data", {16'h0, d}, q);
        for (int i = 0; i < 2; i++) begin
            apb(1, REG_ADDR, {13'h0, i[0], 18'h0});
            op(OP_AUTOSELECT);
            apb(0, REG_RDATA, 0);
            check("protect code", 32'(i), q);
        end
        for (int e = 0; e < 3; e++) begin
            apb(1, REG_ADDR, e == 0 ? 32'h40000 : 32'h00123);
            op(e == 2 ? OP_CHIP_ERASE : OP_SECTOR_ERASE);
            stat(32'h3f, 32'h22);
            op(e == 1 ? OP_SUSPEND : OP_RESUME);
            stat(32'h3f, 32'h22);
            foreach (exp_mem[k]) begin
                if (e == 2 || (e == 1 && k[18:12] == 7'h00)) exp_mem[k] = 16'hffff;
                apb(1, REG_ADDR, k);
                op(OP_READ);
                apb(0, REG_RDATA, 0);
                check("erase", {16'h0, exp_mem[k]}, q);
            end
        end
        final_report();
    end
endmodule : fwsr_host_test
